// File: verilog/tmw_pkg.sv
/*
 * Shared constants and types for the 8-bit waveform timer: register
 * offsets, field layout, mode and action codes, reset values.
 * Assumes an APB master with 32-bit data and byte addressing.
 */
package tmw_pkg;

	localparam int TMW_CNT_W = 8;
	localparam int TMW_ADDR_W = 8;
	localparam int TMW_PRESCALE_W = 10;

	// Register byte offsets
	localparam logic [7:0] TMW_OFF_CTRL = 8'h00;
	localparam logic [7:0] TMW_OFF_COUNT = 8'h04;
	localparam logic [7:0] TMW_OFF_CMP_A = 8'h08;
	localparam logic [7:0] TMW_OFF_CMP_B = 8'h0C;
	localparam logic [7:0] TMW_OFF_FLAGS = 8'h10;
	localparam logic [7:0] TMW_OFF_PIN_DIR = 8'h14;

	// Write-only strobes in the control word
	localparam int TMW_CTRL_FORCE_A_BIT = 12;
	localparam int TMW_CTRL_FORCE_B_BIT = 13;
	// Flag bits, write one to clear
	localparam int TMW_FLAG_OVF_BIT = 0;
	localparam int TMW_FLAG_CMP_A_BIT = 1;
	localparam int TMW_FLAG_CMP_B_BIT = 2;
	// Pin direction bits and read-only level bits
	localparam int TMW_DIR_A_BIT = 0;
	localparam int TMW_DIR_B_BIT = 1;
	localparam int TMW_LEVEL_A_BIT = 8;
	localparam int TMW_LEVEL_B_BIT = 9;

	// Waveform mode codes
	localparam logic [2:0] TMW_MODE_NORMAL = 3'h0;
	localparam logic [2:0] TMW_MODE_PC_MAX = 3'h1;
	localparam logic [2:0] TMW_MODE_CTC = 3'h2;
	localparam logic [2:0] TMW_MODE_FAST_MAX = 3'h3;
	localparam logic [2:0] TMW_MODE_PC_CMP = 3'h5;
	localparam logic [2:0] TMW_MODE_FAST_CMP = 3'h7;

	// Compare output actions
	localparam logic [1:0] TMW_ACT_OFF = 2'h0;
	localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TMW_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TMW_ACT_SET = 2'h3;

	localparam logic [7:0] TMW_MAX = 8'hFF;
	localparam logic [7:0] TMW_BOTTOM = 8'h00;
	localparam logic [7:0] TMW_RESET_BYTE = 8'h00;
	localparam logic [31:0] TMW_RESET_WORD = 32'h0000_0000;

	typedef struct packed {
		logic [2:0] clk_sel;
		logic [1:0] compare_output_action_b;
		logic [1:0] compare_output_action_a;
		logic [2:0] waveform_mode_sel;
	} tmw_ctrl_t;

	localparam int TMW_CTRL_W = $bits(tmw_ctrl_t);

	typedef enum logic [3:0] {
		TMW_CLS_NORMAL = 4'b0001,
		TMW_CLS_CTC = 4'b0010,
		TMW_CLS_FAST = 4'b0100,
		TMW_CLS_PHASE = 4'b1000
	} tmw_cls_t;

	function automatic tmw_cls_t tmw_mode_class(input logic [2:0] mode);
		case (mode)
			TMW_MODE_CTC: return TMW_CLS_CTC;
			TMW_MODE_FAST_MAX, TMW_MODE_FAST_CMP: return TMW_CLS_FAST;
			TMW_MODE_PC_MAX, TMW_MODE_PC_CMP: return TMW_CLS_PHASE;
			default: return TMW_CLS_NORMAL;
		endcase
	endfunction : tmw_mode_class

endpackage : tmw_pkg

// File: verilog/tmw_prescaler.sv
/*
 * Timer clock enable generator: a free-running divider and a one-cycle
 * tick at the selected rate, or none when stopped.
 * Assumes the core clock is the I/O clock.
 */
`timescale 1ns/1ps
module tmw_prescaler import tmw_pkg::*; #(
	parameter int DIV_W = TMW_PRESCALE_W
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// Rate select, 0 stops the timer
	input wire logic [2:0] clk_sel_in,
	// Timer clock enable
	output logic tick_out
);

	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] mask;

	always_comb begin
		case (clk_sel_in)
			3'h2: mask = DIV_W'(7);
			3'h3: mask = DIV_W'(31);
			3'h4: mask = DIV_W'(63);
			3'h5: mask = DIV_W'(127);
			3'h6: mask = DIV_W'(255);
			3'h7: mask = DIV_W'(1023);
			default: mask = '0;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (clk_sel_in != 3'h0) && ((div_q & mask) == mask);
		end
	end

endmodule : tmw_prescaler

// File: verilog/tmw_timer8.sv
/*
 * 8-bit timer/counter with two compare channels and four waveform
 * classes, reached over an APB slave; drives two waveform pins.
 * Assumes APB master timing and pins routed straight to pads.
 */
// The implementer's own choices: register access over APB and the register offsets.
// Functional notes
// - Waveform mode sets counting; output action only shapes outputs.
// - Mode 0 always counts up, wrapping 0xFF to 0x00.
// - Normal mode sets overflow flag as count becomes zero; never clears it.
// - Mode 2 clears the counter on match with compare A as TOP.
// - CTC compare A written directly; a value below count waits a full wrap.
// - CTC action 1 toggles output A at every match.
// - CTC sets overflow flag when the counter goes from max to zero.
// - Timer tick selectable as clock divided by 1,8,32,64,128,256,1024.
// - Modes 3 and 7 fast PWM; TOP 0xFF or compare A.
// - Fast PWM counts up to TOP, cleared on the next tick.
// - Fast PWM action 2 clears on match sets at bottom; 3 inverse.
// - Fast PWM sets overflow flag each time the counter reaches TOP.
// - Fast PWM compare zero gives a spike; compare max gives steady level.
// - Fast PWM action 1 toggles output A on match, double buffering still active; B unchanged.
// - Modes 1 and 5 phase correct: count up to TOP then down.
// - Phase correct reverses at TOP, holding TOP for one tick.
// - Phase correct action 2 clears on up match, sets on down; 3 inverse.
// - Phase correct sets overflow flag each time the counter reaches bottom.
// - Phase correct compare zero steady low, max steady high; inverted opposite.
// - Phase correct forces up-match level at bottom after missed match.
// - Waveform level reaches the pin only when its direction is output.
// - PWM compare writes buffered, loaded at TOP; other modes direct.
// - A compare match sets its flag on the following tick.
// - Action 0 leaves the output register unchanged on match.
`timescale 1ns/1ps
module tmw_timer8 import tmw_pkg::*; (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [TMW_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Waveform pins
	output logic wave_out_a_out,
	output logic wave_out_a_oe_out,
	output logic wave_out_b_out,
	output logic wave_out_b_oe_out
);

	tmw_ctrl_t ctrl_q;
	logic [TMW_CNT_W-1:0] count_value_q;
	logic count_down_q;
	logic block_q;
	logic [2:0] flags_q;
	logic [1:0] pin_dir_q;
	logic [TMW_CNT_W-1:0] cmp_act_q [2];
	logic [TMW_CNT_W-1:0] cmp_buf_q [2];
	logic [1:0] wave_q;
	logic [1:0] fix_q;
	logic [1:0] up_hit_q;
	logic [31:0] rd_data;
	logic tick;
	tmw_cls_t cls;
	logic pwm;
	logic [TMW_CNT_W-1:0] top_val;
	logic at_top;
	logic pc_up;
	logic bottom_evt;
	logic access;
	logic wr_fire;
	logic [1:0] hit;
	logic [1:0] force_hit;
	logic [1:0] cmp_wr;
	logic [1:0] action [2];
	logic [2:0] flag_set;
	logic [2:0] flag_clr;

	function automatic logic tmw_mapped(input logic [TMW_ADDR_W-1:0] a);
		return (a == TMW_OFF_CTRL) || (a == TMW_OFF_COUNT) || (a == TMW_OFF_CMP_A) ||
			(a == TMW_OFF_CMP_B) || (a == TMW_OFF_FLAGS) || (a == TMW_OFF_PIN_DIR);
	endfunction : tmw_mapped

	// Next output level for one channel on a tick or forced match
	function automatic logic tmw_wave_next(input logic cur, input logic [1:0] act,
		input tmw_cls_t c, input logic m, input logic up, input logic bot,
		input logic fix, input logic chan_a);
		logic r;
		r = cur;
		case (c)
			TMW_CLS_FAST: begin
				if (m && act == TMW_ACT_TOGGLE && chan_a) begin
					r = ~cur;
				end else if (m && act == TMW_ACT_CLEAR) begin
					r = 1'b0;
				end else if (m && act == TMW_ACT_SET) begin
					r = 1'b1;
				end
				// Bottom wins so compare at max holds a steady level
				if (bot && act == TMW_ACT_CLEAR) begin
					r = 1'b1;
				end else if (bot && act == TMW_ACT_SET) begin
					r = 1'b0;
				end
			end
			TMW_CLS_PHASE: begin
				if (bot && fix && act[1]) begin
					r = (act == TMW_ACT_SET);
				end
				if (m && act == TMW_ACT_CLEAR) begin
					r = ~up;
				end else if (m && act == TMW_ACT_SET) begin
					r = up;
				end
			end
			default: begin
				if (m) begin
					case (act)
						TMW_ACT_TOGGLE: r = ~cur;
						TMW_ACT_CLEAR: r = 1'b0;
						TMW_ACT_SET: r = 1'b1;
						default: r = cur;
					endcase
				end
			end
		endcase
		return r;
	endfunction : tmw_wave_next

	tmw_prescaler #(
		.DIV_W(TMW_PRESCALE_W)
	) u_prescaler (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.clk_sel_in(ctrl_q.clk_sel),
		.tick_out(tick)
	);

	// Bus decode; writes commit on the edge where pready is seen high
	assign access = psel_in && penable_in && !pready_out;
	assign wr_fire = psel_in && penable_in && pready_out && pwrite_in;
	assign cmp_wr[0] = wr_fire && paddr_in == TMW_OFF_CMP_A;
	assign cmp_wr[1] = wr_fire && paddr_in == TMW_OFF_CMP_B;

	// Mode decode from the waveform bits alone
	assign cls = tmw_mode_class(ctrl_q.waveform_mode_sel);
	assign pwm = (cls == TMW_CLS_FAST) || (cls == TMW_CLS_PHASE);
	assign action[0] = ctrl_q.compare_output_action_a;
	assign action[1] = ctrl_q.compare_output_action_b;

	always_comb begin
		case (ctrl_q.waveform_mode_sel)
			TMW_MODE_CTC, TMW_MODE_FAST_CMP, TMW_MODE_PC_CMP: top_val = cmp_act_q[0];
			default: top_val = TMW_MAX;
		endcase
	end

	assign at_top = count_value_q == top_val;
	// A match at bottom counts as rising, one at TOP as falling
	assign pc_up = (!count_down_q && !at_top) || count_value_q == TMW_BOTTOM;
	assign bottom_evt = (cls == TMW_CLS_FAST) ? at_top :
		(cls == TMW_CLS_PHASE) && count_down_q && count_value_q == TMW_BOTTOM;

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= TMW_RESET_WORD;
		end else begin
			pready_out <= access;
			pslverr_out <= access && !tmw_mapped(paddr_in);
			prdata_out <= (access && !pwrite_in) ? rd_data : TMW_RESET_WORD;
		end
	end

	always_comb begin
		rd_data = TMW_RESET_WORD;
		case (paddr_in)
			TMW_OFF_CTRL: rd_data[TMW_CTRL_W-1:0] = ctrl_q;
			TMW_OFF_COUNT: rd_data[TMW_CNT_W-1:0] = count_value_q;
			TMW_OFF_CMP_A: rd_data[TMW_CNT_W-1:0] = cmp_buf_q[0];
			TMW_OFF_CMP_B: rd_data[TMW_CNT_W-1:0] = cmp_buf_q[1];
			TMW_OFF_FLAGS: rd_data[2:0] = flags_q;
			TMW_OFF_PIN_DIR: begin
				rd_data[TMW_DIR_B_BIT:TMW_DIR_A_BIT] = pin_dir_q;
				rd_data[TMW_LEVEL_B_BIT:TMW_LEVEL_A_BIT] = wave_q;
			end
			default: rd_data = TMW_RESET_WORD;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_q <= '0;
			pin_dir_q <= 2'h0;
		end else begin
			if (wr_fire && paddr_in == TMW_OFF_CTRL) begin
				ctrl_q <= pwdata_in[TMW_CTRL_W-1:0];
			end
			if (wr_fire && paddr_in == TMW_OFF_PIN_DIR) begin
				pin_dir_q <= pwdata_in[TMW_DIR_B_BIT:TMW_DIR_A_BIT];
			end
		end
	end

	// Counter and direction; a bus write overrides counting
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_value_q <= TMW_RESET_BYTE;
			count_down_q <= 1'b0;
		end else if (wr_fire && paddr_in == TMW_OFF_COUNT) begin
			count_value_q <= pwdata_in[TMW_CNT_W-1:0];
		end else if (tick) begin
			case (cls)
				TMW_CLS_CTC: begin
					// Missed TOP runs on through the wrap
					count_value_q <= hit[0] ? TMW_BOTTOM : count_value_q + 8'h01;
					count_down_q <= 1'b0;
				end
				TMW_CLS_FAST: begin
					count_value_q <= at_top ? TMW_BOTTOM : count_value_q + 8'h01;
					count_down_q <= 1'b0;
				end
				TMW_CLS_PHASE: begin
					if (!count_down_q && at_top) begin
						count_down_q <= 1'b1;
						count_value_q <= count_value_q - 8'h01;
					end else if (count_down_q && count_value_q == TMW_BOTTOM) begin
						count_down_q <= 1'b0;
						count_value_q <= count_value_q + 8'h01;
					end else if (count_down_q) begin
						count_value_q <= count_value_q - 8'h01;
					end else begin
						count_value_q <= count_value_q + 8'h01;
					end
				end
				default: begin
					count_value_q <= count_value_q + 8'h01;
					count_down_q <= 1'b0;
				end
			endcase
		end
	end

	// A counter write hides matches until the next tick
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			block_q <= 1'b0;
		end else if (wr_fire && paddr_in == TMW_OFF_COUNT) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// Flags: hardware set beats a same-cycle software clear
	always_comb begin
		flag_set = 3'h0;
		flag_clr = 3'h0;
		if (wr_fire && paddr_in == TMW_OFF_FLAGS) begin
			flag_clr = pwdata_in[2:0];
		end
		if (tick) begin
			case (cls)
				TMW_CLS_FAST: flag_set[TMW_FLAG_OVF_BIT] = at_top;
				TMW_CLS_PHASE: flag_set[TMW_FLAG_OVF_BIT] = bottom_evt;
				TMW_CLS_CTC: flag_set[TMW_FLAG_OVF_BIT] = count_value_q == TMW_MAX;
				default: flag_set[TMW_FLAG_OVF_BIT] = count_value_q == TMW_MAX;
			endcase
			flag_set[TMW_FLAG_CMP_A_BIT] = hit[0];
			flag_set[TMW_FLAG_CMP_B_BIT] = hit[1];
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flags_q <= 3'h0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	generate
		for (genvar i = 0; i < 2; i++) begin : g_chan
			assign hit[i] = count_value_q == cmp_act_q[i] && !block_q;
			assign force_hit[i] = wr_fire && paddr_in == TMW_OFF_CTRL && !pwm &&
				pwdata_in[TMW_CTRL_FORCE_A_BIT + i];

			// Compare value: direct in non-PWM, loaded at TOP in PWM
			always_ff @(posedge core_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					cmp_buf_q[i] <= TMW_RESET_BYTE;
					cmp_act_q[i] <= TMW_RESET_BYTE;
				end else begin
					if (cmp_wr[i]) begin
						cmp_buf_q[i] <= pwdata_in[TMW_CNT_W-1:0];
					end
					if (cmp_wr[i] && !pwm) begin
						cmp_act_q[i] <= pwdata_in[TMW_CNT_W-1:0];
					end else if (tick && pwm && at_top && !count_down_q) begin
						cmp_act_q[i] <= cmp_buf_q[i];
					end
				end
			end

			// Missed rising match or compare leaving max
			always_ff @(posedge core_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					fix_q[i] <= 1'b0;
					up_hit_q[i] <= 1'b0;
				end else if (cls != TMW_CLS_PHASE) begin
					fix_q[i] <= 1'b0;
					up_hit_q[i] <= 1'b0;
				end else if (tick) begin
					if (bottom_evt) begin
						fix_q[i] <= 1'b0;
						up_hit_q[i] <= hit[i];
					end else if (at_top && !count_down_q) begin
						fix_q[i] <= (cmp_act_q[i] == TMW_MAX && cmp_buf_q[i] != TMW_MAX) ||
							(!up_hit_q[i] && cmp_act_q[i] != top_val);
					end else if (hit[i] && pc_up) begin
						up_hit_q[i] <= 1'b1;
					end
				end
			end

			always_ff @(posedge core_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					wave_q[i] <= 1'b0;
				end else if (tick || force_hit[i]) begin
					// Force acts as a match without flag or counter clear
					wave_q[i] <= tmw_wave_next(wave_q[i], action[i], cls,
						(tick && hit[i]) || force_hit[i], pc_up, tick && bottom_evt,
						fix_q[i], i == 0);
				end
			end
		end
	endgenerate

	// Pin drive; registered copies keep outputs straight from flops
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wave_out_a_out <= 1'b0;
			wave_out_b_out <= 1'b0;
			wave_out_a_oe_out <= 1'b0;
			wave_out_b_oe_out <= 1'b0;
		end else begin
			wave_out_a_out <= wave_q[0];
			wave_out_b_out <= wave_q[1];
			wave_out_a_oe_out <= pin_dir_q[TMW_DIR_A_BIT] && (action[0] != TMW_ACT_OFF);
			wave_out_b_oe_out <= pin_dir_q[TMW_DIR_B_BIT] && (action[1] != TMW_ACT_OFF);
		end
	end

endmodule : tmw_timer8

// File: tb/tmw_timer8_properties.sv
/* Port checker for tmw_timer8: APB answer timing, error decode, pin enables.
 * Assumes a master that holds each request until pready is sampled high. */
`timescale 1ns/1ps
module tmw_timer8_properties import tmw_pkg::*; (
	// Watched ports
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [TMW_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic wave_out_a_out,
	input wire logic wave_out_a_oe_out,
	input wire logic wave_out_b_out,
	input wire logic wave_out_b_oe_out
);
	logic [1:0] dir_q;
	logic [1:0] act_q;
	logic wr_w;
	logic bad_w;
	logic [1:0] en_w;
	assign wr_w = psel_in && penable_in && pready_out && pwrite_in;
	assign bad_w = paddr_in > TMW_OFF_PIN_DIR || paddr_in[1:0] != 2'h0;
	// Shadow of what software asked for, to judge the pin enables
	assign en_w = dir_q & act_q;
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) dir_q <= 2'h0;
		else if (wr_w && paddr_in == TMW_OFF_PIN_DIR) dir_q <= pwdata_in[1:0];
	end
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) act_q <= 2'h0;
		else if (wr_w && paddr_in == TMW_OFF_CTRL) act_q <= {|pwdata_in[6:5], |pwdata_in[4:3]};
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	ready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("no answer one cycle after access");
	ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready held");
	ready_cause_a: assert property ($rose(pready_out) |-> $past(psel_in && penable_in))
		else $error("ready without access");
	rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data outside answer");
	err_decode_a: assert property (pready_out |-> pslverr_out == bad_w)
		else $error("error flag wrong for address");
	err_data_a: assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
		else $error("refused read returned data");
	pin_en_a_a: assert property (en_w[0] == $past(en_w[0]) |-> wave_out_a_oe_out == en_w[0])
		else $error("pin A enable wrong");
	pin_en_b_a: assert property (en_w[1] == $past(en_w[1]) |-> wave_out_b_oe_out == en_w[1])
		else $error("pin B enable wrong");
endmodule : tmw_timer8_properties

// File: tb/tmw_load.sv
/* Load on one waveform pin: resolves the pad and counts its high cycles.
 * Assumes a pull-down on the pad, so an undriven pin reads low. */
`timescale 1ns/1ps
module tmw_load (
	// Clock and window restart
	input wire logic core_clk_in,
	input wire logic clr_in,
	// Pin
	input wire logic level_in,
	input wire logic oe_in,
	// Observed
	output logic pad_out,
	output logic [15:0] high_cnt_out
);
	assign pad_out = oe_in ? level_in : 1'b0;
	always_ff @(posedge core_clk_in) begin
		if (clr_in) high_cnt_out <= 16'h0;
		else high_cnt_out <= high_cnt_out + 16'(pad_out);
	end
endmodule : tmw_load

// File: tb/tmw_timer8_tb.sv
/* Self-checking bench for tmw_timer8: register tests over APB, duty of both
 * pins measured by load models. Assumes a 100 MHz core clock. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module tmw_timer8_tb import tmw_pkg::*;;
	typedef struct packed {
		logic [2:0] m;
		logic [1:0] aa, ab;
		logic [7:0] ca, cb;
		logic [15:0] win, ea, eb;
	} tmw_case_t;
	// Windows are whole periods, so the count is exact whatever the phase
	localparam tmw_case_t PWM_CASES [9] = '{
		'{3'h3, 2'h2, 2'h3, 8'h40, 8'h40, 16'h200, 16'h82, 16'h17E},
		'{3'h3, 2'h2, 2'h2, 8'h00, 8'hFF, 16'h200, 16'h2, 16'h200},
		'{3'h3, 2'h3, 2'h3, 8'hFF, 8'h00, 16'h200, 16'h0, 16'h1FE},
		'{3'h1, 2'h2, 2'h3, 8'h40, 8'h40, 16'h3FC, 16'h100, 16'h2FC},
		'{3'h1, 2'h2, 2'h2, 8'h00, 8'hFF, 16'h3FC, 16'h0, 16'h3FC},
		'{3'h1, 2'h3, 2'h3, 8'h00, 8'hFF, 16'h3FC, 16'h3FC, 16'h0},
		'{3'h7, 2'h1, 2'h2, 8'h3F, 8'h0F, 16'h200, 16'h100, 16'h80},
		'{3'h5, 2'h0, 2'h2, 8'h3F, 8'h10, 16'h1F8, 16'h0, 16'h80},
		'{3'h2, 2'h1, 2'h0, 8'h0F, 8'h00, 16'h200, 16'h100, 16'h0}};
	localparam int SHIFT [8] = '{0, 0, 3, 5, 6, 7, 8, 10};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, wa, wa_oe, wb, wb_oe;
	logic [15:0] hi_a, hi_b;
	int error_cnt = 0;
	int samples_checked = 0;
	tmw_timer8 uut (
		.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .wave_out_a_out(wa),
		.wave_out_a_oe_out(wa_oe), .wave_out_b_out(wb), .wave_out_b_oe_out(wb_oe));
	tmw_load load_a (.core_clk_in(clk), .clr_in(clr), .level_in(wa), .oe_in(wa_oe),
		.pad_out(), .high_cnt_out(hi_a));
	tmw_load load_b (.core_clk_in(clk), .clr_in(clr), .level_in(wb), .oe_in(wb_oe),
		.pad_out(), .high_cnt_out(hi_b));
	initial forever #5 clk = ~clk;
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	// Entered just after a rising edge; leaves one idle edge so psel never doubles up
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		`CHK(n < 20, 1'b1)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : chk_rd
	task automatic ctrl(input logic [2:0] cs, input logic [1:0] ab, aa, input logic [2:0] m);
		tmw_ctrl_t c;
		c = '{cs, ab, aa, m};
		wr(TMW_OFF_CTRL, 32'(c));
	endtask : ctrl
	task automatic run(input int n);
		repeat (n) @(posedge clk);
	endtask : run
	initial begin
		tmw_case_t c;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 24; a += 4) chk_rd(8'(a), 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		`CHK(err, 1'b1)
		wr(8'h1C, 32'hFFFF_FFFF);
		`CHK(err, 1'b1)
		wr(TMW_OFF_PIN_DIR, 32'h303);
		chk_rd(TMW_OFF_PIN_DIR, 32'h3);
		wr(TMW_OFF_CMP_A, 32'h5);
		wr(TMW_OFF_COUNT, 32'hFE);
		ctrl(3'h1, 2'h0, 2'h0, TMW_MODE_NORMAL);
		run(20);
		ctrl(3'h0, 2'h0, 2'h0, TMW_MODE_NORMAL);
		apb(1'b0, TMW_OFF_COUNT, 32'h0);
		`CHK(rd, 32'h16)
		chk_rd(TMW_OFF_FLAGS, 32'h7);
		wr(TMW_OFF_FLAGS, 32'h7);
		chk_rd(TMW_OFF_FLAGS, 32'h0);
		wr(TMW_OFF_CMP_A, 32'h10);
		wr(TMW_OFF_COUNT, 32'h20);
		wr(TMW_OFF_FLAGS, 32'h7);
		ctrl(3'h1, 2'h0, 2'h0, TMW_MODE_CTC);
		run(100);
		ctrl(3'h0, 2'h0, 2'h0, TMW_MODE_CTC);
		apb(1'b0, TMW_OFF_COUNT, 32'h0);
		`CHK(rd, 32'h88)
		apb(1'b0, TMW_OFF_FLAGS, 32'h0);
		`CHK(rd[0], 1'b0)
		ctrl(3'h1, 2'h0, 2'h0, TMW_MODE_CTC);
		run(300);
		ctrl(3'h0, 2'h0, 2'h0, TMW_MODE_CTC);
		apb(1'b0, TMW_OFF_COUNT, 32'h0);
		`CHK(rd, 32'h0E)
		apb(1'b0, TMW_OFF_FLAGS, 32'h0);
		`CHK(rd[0], 1'b1)
		// The two control writes add four tick slots: window is exactly 16 periods
		for (int s = 1; s < 8; s++) begin
			wr(TMW_OFF_COUNT, 32'h0);
			ctrl(3'(s), 2'h0, 2'h0, TMW_MODE_NORMAL);
			run((16 << SHIFT[s]) - 4);
			ctrl(3'h0, 2'h0, 2'h0, TMW_MODE_NORMAL);
			apb(1'b0, TMW_OFF_COUNT, 32'h0);
			`CHK(rd, 32'h10)
		end
		foreach (PWM_CASES[i]) begin
			c = PWM_CASES[i];
			ctrl(3'h0, 2'h0, 2'h0, TMW_MODE_NORMAL);
			wr(TMW_OFF_COUNT, 32'h0);
			wr(TMW_OFF_CMP_A, {24'h0, c.ca});
			wr(TMW_OFF_CMP_B, {24'h0, c.cb});
			ctrl(3'h1, c.ab, c.aa, c.m);
			run(1100);
			wr(TMW_OFF_FLAGS, 32'h7);
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			run(int'(c.win));
			#1;
			`CHK(hi_a, c.ea)
			`CHK(hi_b, c.eb)
			@(posedge clk);
			apb(1'b0, TMW_OFF_FLAGS, 32'h0);
			`CHK(rd[0], c.m != TMW_MODE_CTC)
		end
		wr(TMW_OFF_PIN_DIR, 32'h0);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		run(64);
		#1;
		`CHK(hi_a, 16'h0)
		// Force uses the action already held, so actions go one write ahead
		ctrl(3'h0, 2'h0, TMW_ACT_SET, TMW_MODE_NORMAL);
		wr(TMW_OFF_CTRL, 32'h0000_1018);
		apb(1'b0, TMW_OFF_PIN_DIR, 32'h0);
		`CHK(rd[TMW_LEVEL_A_BIT], 1'b1)
		ctrl(3'h0, 2'h0, TMW_ACT_OFF, TMW_MODE_NORMAL);
		wr(TMW_OFF_CTRL, 32'h0000_1000);
		apb(1'b0, TMW_OFF_PIN_DIR, 32'h0);
		`CHK(rd[TMW_LEVEL_A_BIT], 1'b1)
		ctrl(3'h0, 2'h0, TMW_ACT_CLEAR, TMW_MODE_NORMAL);
		wr(TMW_OFF_CTRL, 32'h0000_1010);
		apb(1'b0, TMW_OFF_PIN_DIR, 32'h0);
		`CHK(rd[TMW_LEVEL_A_BIT], 1'b0)
		final_report();
	end
	initial begin
		#900000;
		error_cnt++;
		final_report();
	end
endmodule : tmw_timer8_tb
bind tmw_timer8 tmw_timer8_properties props (
	.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .wave_out_a_out(wave_out_a_out),
	.wave_out_a_oe_out(wave_out_a_oe_out), .wave_out_b_out(wave_out_b_out),
	.wave_out_b_oe_out(wave_out_b_oe_out));
